//--- src/remap_out_pkg.sv
// Package with register map, field layout and encodings of the output remapping unit
package remap_out_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word per register)
	// ------------------------------------------------------------
	localparam int          NUM_REGS       = 8;
	localparam int          NUM_PINS       = 16;
	localparam int          ADDR_W         = 6;
	localparam logic [5:0]  OUT_MAP_BASE   = 6'h00;
	localparam logic [5:0]  OUT_MAP_LAST   = 6'h1c;
	localparam int          REG_IDX_LSB    = 2;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int          SEL_W          = 5;
	localparam int          EVEN_LSB       = 0;
	localparam int          ODD_LSB        = 8;
	localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
	localparam logic [31:0] IMPL_MASK      = 32'h00001f1f;

	// ------------------------------------------------------------
	// Function codes and bus answers
	// ------------------------------------------------------------
	localparam int          NUM_FUNCS      = 32;
	localparam logic [31:0] FUNC_IMPL_DFLT = 32'h000007fe;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef logic [SEL_W-1:0] sel_t;

endpackage

//--- src/pin_route.sv
// One remappable pin: picks a peripheral output or falls back to port control
`timescale 1ns/100ps
module pin_route
	import remap_out_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [4:0]           sel,
	input  wire logic [NUM_FUNCS-1:0] func_impl,
	input  wire logic [NUM_FUNCS-1:0] periph_out,
	input  wire logic [NUM_FUNCS-1:0] periph_oe,
	input  wire logic                 port_out,
	input  wire logic                 port_oe,
	output logic                      pin_out,
	output logic                      pin_oe,
	output logic                      pin_mapped
);

	logic nxt_out;
	logic nxt_oe;
	logic nxt_mapped;

	// Unimplemented code leaves the pin to the general-purpose port
	always_comb begin
		nxt_mapped = func_impl[sel]; // R08
		nxt_out    = nxt_mapped ? periph_out[sel] : port_out;
		nxt_oe     = nxt_mapped ? periph_oe[sel] : port_oe;
	end

	// Registered driver keeps pin data glitch free when the selection changes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out    <= 1'b0;
			pin_oe     <= 1'b0;
			pin_mapped <= 1'b0;
		end else begin
			pin_out    <= nxt_out;
			pin_oe     <= nxt_oe;
			pin_mapped <= nxt_mapped;
		end
	end

endmodule

//--- src/remappable_output_select.sv
// Output side of the peripheral-to-pin remapping unit with its AXI4-Lite register slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
// Overview of operation
// R01 - Bits 12 to 8 of each select register choose the function driving the odd pin of its pair.
// R02 - Bits 4 to 0 of each select register choose the function driving the even pin of its pair.
// R03 - Eight registers cover pins 0 to 15 in ascending pairs, register n holding pins 2n and 2n+1.
// R04 - Bits 15 to 13 read as zero and ignore writes.
// R05 - Bits 7 to 5 read as zero and ignore writes.
// R06 - All selection bits are read/write and read back the last value written.
// R07 - Reset clears every selection field to function code zero.
// R08 - A code naming no implemented function leaves the pin under ordinary port control.
module remappable_output_select
	import remap_out_pkg::*;
#(
	parameter logic [NUM_FUNCS-1:0] FUNC_IMPL = FUNC_IMPL_DFLT
)
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Peripheral side
	input  wire logic [NUM_FUNCS-1:0] periph_out,
	input  wire logic [NUM_FUNCS-1:0] periph_oe,
	input  wire logic [NUM_PINS-1:0]  port_out,
	input  wire logic [NUM_PINS-1:0]  port_oe,
	// Pin drivers
	output logic [NUM_PINS-1:0]       remappable_pin_out,
	output logic [NUM_PINS-1:0]       remappable_pin_oe,
	output logic [NUM_PINS-1:0]       remappable_pin_mapped
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Maps a byte address to a register index, flags unmapped offsets
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a >= OUT_MAP_BASE) && (a <= OUT_MAP_LAST) && (a[REG_IDX_LSB-1:0] == '0);
	endfunction

	function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
		addr_idx = a[REG_IDX_LSB+2:REG_IDX_LSB];
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_GOT_A = 2'b01,
		WR_GOT_D = 2'b10,
		WR_RESP = 2'b11
	} wr_state_t;

	wr_state_t        wr_state_ff;
	wr_state_t        nxt_wr_state;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0]      wdata_ff;
	logic [3:0]       wstrb_ff;
	logic             bvalid_ff;
	logic [1:0]       bresp_ff;
	logic             rvalid_ff;
	logic [31:0]      rdata_ff;
	logic [1:0]       rresp_ff;
	sel_t             even_sel_ff [NUM_REGS];
	sel_t             odd_sel_ff  [NUM_REGS];
	logic             aw_hs;
	logic             w_hs;
	logic             do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;

	// ------------------------------------------------------------
	// Write channel: address and data taken in either order
	// ------------------------------------------------------------

	// Ready only while that half is still missing, so each is taken once
	always_comb begin
		s_axi_awready = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_GOT_D);
		s_axi_wready  = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_GOT_A);
		aw_hs         = s_axi_awvalid && s_axi_awready;
		w_hs          = s_axi_wvalid && s_axi_wready;
	end

	// Write fires when the second half arrives, merging held and fresh halves
	always_comb begin
		wr_addr  = (wr_state_ff == WR_GOT_A) ? awaddr_ff : s_axi_awaddr;
		wr_data  = (wr_state_ff == WR_GOT_D) ? wdata_ff : s_axi_wdata;
		wr_strb  = (wr_state_ff == WR_GOT_D) ? wstrb_ff : s_axi_wstrb;
		do_write = 1'b0;
		case (wr_state_ff)
			WR_IDLE:  do_write = aw_hs && w_hs;
			WR_GOT_A: do_write = w_hs;
			WR_GOT_D: do_write = aw_hs;
			default:  do_write = 1'b0;
		endcase
	end

	// Write sequencing
	always_comb begin
		nxt_wr_state = wr_state_ff;
		case (wr_state_ff)
			WR_IDLE: begin
				if (aw_hs && w_hs)
					nxt_wr_state = WR_RESP;
				else if (aw_hs)
					nxt_wr_state = WR_GOT_A;
				else if (w_hs)
					nxt_wr_state = WR_GOT_D;
			end
			WR_GOT_A: begin
				if (w_hs)
					nxt_wr_state = WR_RESP;
			end
			WR_GOT_D: begin
				if (aw_hs)
					nxt_wr_state = WR_RESP;
			end
			WR_RESP: begin
				if (s_axi_bready)
					nxt_wr_state = WR_IDLE;
			end
			default: nxt_wr_state = WR_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			wr_state_ff <= WR_IDLE;
		else
			wr_state_ff <= nxt_wr_state;
	end

	// Hold whichever half came first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_ff <= '0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else begin
			if (aw_hs)
				awaddr_ff <= s_axi_awaddr;
			if (w_hs) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	// Write response; unmapped offsets answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// ------------------------------------------------------------
	// Selection registers
	// ------------------------------------------------------------

	// Only implemented bits store; byte lanes follow wstrb, upper lanes hold nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				even_sel_ff[i] <= SEL_RESET; // R07
				odd_sel_ff[i]  <= SEL_RESET; // R07
			end
		end else if (do_write && addr_hit(wr_addr)) begin
			if (wr_strb[0])
				even_sel_ff[addr_idx(wr_addr)] <= wr_data[EVEN_LSB +: SEL_W]; // R02 R05 R06
			if (wr_strb[1])
				odd_sel_ff[addr_idx(wr_addr)] <= wr_data[ODD_LSB +: SEL_W]; // R01 R04 R06
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------

	// One read in flight; arready drops while the answer waits
	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			if (addr_hit(s_axi_araddr)) begin
				// Unimplemented bits 15:13, 7:5 and the upper half read as zero
				rdata_ff <= ({19'h0, odd_sel_ff[addr_idx(s_axi_araddr)], 3'h0,
					even_sel_ff[addr_idx(s_axi_araddr)]}) & IMPL_MASK; // R04 R05 R06
				rresp_ff <= RESP_OKAY;
			end else begin
				rdata_ff <= '0;
				rresp_ff <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// ------------------------------------------------------------
	// Pin routing: register n drives pins 2n and 2n+1
	// ------------------------------------------------------------
	for (genvar n = 0; n < NUM_REGS; n++) begin : g_pair
		pin_route u_even (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.sel        (even_sel_ff[n]), // R02 R03
			.func_impl  (FUNC_IMPL),
			.periph_out (periph_out),
			.periph_oe  (periph_oe),
			.port_out   (port_out[2*n]),
			.port_oe    (port_oe[2*n]),
			.pin_out    (remappable_pin_out[2*n]),
			.pin_oe     (remappable_pin_oe[2*n]),
			.pin_mapped (remappable_pin_mapped[2*n])
		);
		pin_route u_odd (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.sel        (odd_sel_ff[n]), // R01 R03
			.func_impl  (FUNC_IMPL),
			.periph_out (periph_out),
			.periph_oe  (periph_oe),
			.port_out   (port_out[2*n+1]),
			.port_oe    (port_oe[2*n+1]),
			.pin_out    (remappable_pin_out[2*n+1]),
			.pin_oe     (remappable_pin_oe[2*n+1]),
			.pin_mapped (remappable_pin_mapped[2*n+1])
		);
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Selection word as it stood when the read address was offered
	logic [31:0] rd_hold_ff;
	always_ff @(posedge aclk) begin
		rd_hold_ff <= {19'h0, odd_sel_ff[addr_idx(s_axi_araddr)], 3'h0, even_sel_ff[addr_idx(s_axi_araddr)]};
	end

	// Any selection field left nonzero; one term covers every pair after reset
	logic sel_any_set;
	always_comb begin
		sel_any_set = 1'b0;
		for (int i = 0; i < NUM_REGS; i++) begin
			sel_any_set = sel_any_set | (|even_sel_ff[i]) | (|odd_sel_ff[i]);
		end
	end

	// Reset checks carry their own disable so the reset cycles themselves are watched
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Register bus answers
	reserved_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[15:13] == 3'h0) // R04
		else $error("reserved bits 15:13 read nonzero");
	reserved_mid_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[7:5] == 3'h0) // R05
		else $error("reserved bits 7:5 read nonzero");
	read_data_match_a: assert property ((s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr)) // R06
		|=> s_axi_rvalid && s_axi_rdata == rd_hold_ff)
		else $error("read data differs from held selection");
	read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) // R06
		else $error("read not answered next cycle");
	write_lands_odd_a: assert property ((do_write && addr_hit(wr_addr) && wr_strb[1]) // R01 R03
		|=> odd_sel_ff[$past(addr_idx(wr_addr))] == $past(wr_data[ODD_LSB +: SEL_W]))
		else $error("odd field not updated by write");
	write_lands_even_a: assert property ((do_write && addr_hit(wr_addr) && wr_strb[0]) // R02 R03
		|=> even_sel_ff[$past(addr_idx(wr_addr))] == $past(wr_data[EVEN_LSB +: SEL_W]))
		else $error("even field not updated by write");
	write_response_a: assert property (do_write |=> s_axi_bvalid) // R06
		else $error("write not answered next cycle");

	// Reset clears every field and parks the pin drivers
	reset_clears_sel_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !sel_any_set) // R07
		else $error("selection not cleared by reset");
	reset_clears_pins_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn // R07
		|=> remappable_pin_oe == '0 && remappable_pin_mapped == '0)
		else $error("pin drivers not parked by reset");

	// Pins follow the held selection one cycle later
	unmapped_pin_port_a: assert property (!FUNC_IMPL[even_sel_ff[0]] // R08
		|=> remappable_pin_mapped[0] == 1'b0)
		else $error("unimplemented code still mapped pin 0");
	unmapped_pin_drive_a: assert property (!FUNC_IMPL[even_sel_ff[0]] // R08
		|=> remappable_pin_out[0] == $past(port_out[0]) && remappable_pin_oe[0] == $past(port_oe[0]))
		else $error("pin 0 not driven by its port");
	even_pin_drive_a: assert property (FUNC_IMPL[even_sel_ff[0]] // R02 R03
		|=> remappable_pin_mapped[0] && remappable_pin_out[0] == $past(periph_out[even_sel_ff[0]])
		&& remappable_pin_oe[0] == $past(periph_oe[even_sel_ff[0]]))
		else $error("pin 0 not driven by selected function");
	mapped_pin_drive_a: assert property ((FUNC_IMPL[odd_sel_ff[7]] && $stable(odd_sel_ff[7])) // R01 R03
		|=> remappable_pin_out[15] == $past(periph_out[odd_sel_ff[7]]))
		else $error("pin 15 not driven by selected function");
	mapped_pin_oe_a: assert property (FUNC_IMPL[odd_sel_ff[7]] // R01 R03
		|=> remappable_pin_mapped[15] && remappable_pin_oe[15] == $past(periph_oe[odd_sel_ff[7]]))
		else $error("pin 15 enable not from selected function");

	// Main scenarios
	write_cov_c: cover property (do_write && addr_hit(wr_addr));
	read_cov_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
	unmapped_cov_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	bad_read_cov_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	pin_map_cov_c: cover property (remappable_pin_mapped[15]);

endmodule

//--- tb/periph_port_model.sv
// Stand-in for peripheral output functions and port drivers
`timescale 1ns/100ps
module periph_port_model
	import remap_out_pkg::*;
#(
	parameter logic [31:0] SEED = 32'h5a3c96e1
)
(
	input  wire logic            aclk,
	input  wire logic            aresetn,
	output logic [NUM_FUNCS-1:0] periph_out,
	output logic [NUM_FUNCS-1:0] periph_oe,
	output logic [NUM_PINS-1:0]  port_out,
	output logic [NUM_PINS-1:0]  port_oe
);
	logic [31:0] lfsr_ff;
	// Moves every cycle, so a stale or late pick never matches by luck
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lfsr_ff <= SEED;
		end else begin
			lfsr_ff <= {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
		end
	end
	// Outputs drawn from different slices of one pattern
	assign periph_out = lfsr_ff;
	assign periph_oe  = {lfsr_ff[15:0], lfsr_ff[31:16]};
	assign port_out   = lfsr_ff[31:16] ^ lfsr_ff[15:0];
	assign port_oe    = ~lfsr_ff[23:8];
endmodule

//--- tb/tb_remappable_output_select.sv
// Self-checking bench for the output remapping unit
`timescale 1ns/100ps
module tb_remappable_output_select import remap_out_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [31:0] FIMPL = 32'h800007fe;
	logic                 aclk = 1'b0;
	logic                 aresetn = 1'b0;
	logic [ADDR_W-1:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
	logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                 s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0]          s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]           s_axi_wstrb = '0;
	logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]           s_axi_bresp, s_axi_rresp;
	logic [NUM_FUNCS-1:0] periph_out, periph_oe;
	logic [NUM_PINS-1:0]  port_out, port_oe, remappable_pin_out, remappable_pin_oe, remappable_pin_mapped;
	sel_t                 sel_m [NUM_PINS];
	int                   failures = 0;
	int                   comparisons = 0;

	always #5 aclk = ~aclk;

	remappable_output_select #(.FUNC_IMPL(FIMPL)) i_remappable_output_select (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_out(periph_out),
		.periph_oe(periph_oe), .port_out(port_out), .port_oe(port_oe),
		.remappable_pin_out(remappable_pin_out), .remappable_pin_oe(remappable_pin_oe),
		.remappable_pin_mapped(remappable_pin_mapped));

	periph_port_model i_periph_port_model (
		.aclk(aclk), .aresetn(aresetn), .periph_out(periph_out), .periph_oe(periph_oe),
		.port_out(port_out), .port_oe(port_oe));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	// One compare per kind of result: register words, response codes, pin drive
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_pins(input string what, input logic [47:0] exp, input logic [47:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Bus master: tasks start and end on a rising edge
	// ----------------------------------------
	// One loop covers both channels; answers are sampled 1 ns after an edge, 9 ns before the next edge of the 10 ns clock
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rsp);
		logic av, wv, ta, tw, tb;
		int   n;
		// Let an edge pass so a release from the last transfer never meets this request
		@(posedge aclk);
		av = 1'b1;
		wv = 1'b1;
		tb = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while ((av || wv || !tb) && n < 50) begin
			#1;
			ta = av && s_axi_awready;
			tw = wv && s_axi_wready;
			tb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			n++;
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				av = 1'b0;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				wv = 1'b0;
			end
			if (tb) s_axi_bready <= 1'b0;
		end
		if (av || wv || !tb) begin
			failures++;
			$display("[ERR] write handshake expected answer seen timeout");
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rsp);
		logic av, ta, tr;
		int   n;
		// Let an edge pass so rready is never lowered and raised in one time step
		@(posedge aclk);
		av = 1'b1;
		tr = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while ((av || !tr) && n < 50) begin
			#1;
			ta = av && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			n++;
			if (ta) begin
				s_axi_arvalid <= 1'b0;
				av = 1'b0;
			end
			if (tr) s_axi_rready <= 1'b0;
		end
		if (av || !tr) begin
			failures++;
			$display("[ERR] read handshake expected answer seen timeout");
			report_and_stop();
		end
	endtask

	// ----------------------------------------
	// Expectations and register helpers
	// ----------------------------------------
	function automatic logic [31:0] exp_reg(input int r);
		return {19'h0, sel_m[2*r+1], 3'h0, sel_m[2*r]};
	endfunction

	// Pins take the function when implemented, else the port; one cycle late
	function automatic logic [47:0] exp_pins();
		logic [47:0] e;
		for (int p = 0; p < NUM_PINS; p++) begin
			e[p] = FIMPL[sel_m[p]] ? periph_out[sel_m[p]] : port_out[p];
			e[16+p] = FIMPL[sel_m[p]] ? periph_oe[sel_m[p]] : port_oe[p];
			e[32+p] = FIMPL[sel_m[p]];
		end
		return e;
	endfunction

	task automatic check_pins();
		logic [47:0] e;
		#1;
		e = exp_pins();
		@(posedge aclk);
		#1;
		chk_pins("pin drive", e, {remappable_pin_mapped, remappable_pin_oe, remappable_pin_out});
		@(posedge aclk);
	endtask

	task automatic write_reg(input int r, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] rsp;
		wr(6'(4*r), d, s, rsp);
		if (s[0]) sel_m[2*r] = d[4:0];
		if (s[1]) sel_m[2*r+1] = d[12:8];
		chk_resp("write response", RESP_OKAY, rsp);
	endtask

	task automatic check_reg(input int r);
		logic [31:0] d;
		logic [1:0]  rsp;
		rd(6'(4*r), d, rsp);
		chk_word("read data", exp_reg(r), d);
		chk_resp("read response", RESP_OKAY, rsp);
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (sel_m[p]) sel_m[p] = '0;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  rsp;
		logic [5:0]  bad [2];
		bad = '{6'h20, 6'h06};
		void'($urandom(32'he81a));
		do_reset();
		// Cleared selections, pins on port control
		for (int i = 0; i < NUM_REGS; i++) check_reg(i);
		check_pins();
		// Every code in both fields, reserved bits set in the write
		for (int c = 0; c < NUM_FUNCS; c++) begin
			write_reg(c % NUM_REGS, {19'h7ffff, 5'(c), 3'h7, 5'(c)}, 4'hf);
			check_reg(c % NUM_REGS);
			check_pins();
		end
		// Random data and lane strobes, read straight after the write
		for (int i = 0; i < 40; i++) begin
			int r;
			r = $urandom % NUM_REGS;
			write_reg(r, $urandom, 4'($urandom));
			check_reg(r);
			check_pins();
		end
		// Unmapped and misaligned places refuse and leave selections alone
		foreach (bad[k]) begin
			wr(bad[k], 32'hffffffff, 4'hf, rsp);
			chk_resp("bad write response", RESP_SLVERR, rsp);
			rd(bad[k], d, rsp);
			chk_word("bad read data", 32'h0, d);
			chk_resp("bad read response", RESP_SLVERR, rsp);
		end
		for (int i = 0; i < NUM_REGS; i++) check_reg(i);
		// Reset in mid-run clears everything again
		do_reset();
		for (int i = 0; i < NUM_REGS; i++) check_reg(i);
		check_pins();
		report_and_stop();
	end
endmodule
